/* File: core/sstap_top.v */
// test access port: controller, instruction and data registers
`timescale 1ns/10ps
`default_nettype none
`include "sstap_consts.vh"
module sstap_top (
    input wire clk_in,
    input wire rst_n_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire [106:0] ring_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    output reg mem_hiz_out
);
    // ****************************************
    // controller states
    // ****************************************
    localparam [15:0] ST_RESET = 16'h0001;
    localparam [15:0] ST_IDLE = 16'h0002;
    localparam [15:0] ST_SEL_DR = 16'h0004;
    localparam [15:0] ST_CAP_DR = 16'h0008;
    localparam [15:0] ST_SH_DR = 16'h0010;
    localparam [15:0] ST_EX1_DR = 16'h0020;
    localparam [15:0] ST_PA_DR = 16'h0040;
    localparam [15:0] ST_EX2_DR = 16'h0080;
    localparam [15:0] ST_UP_DR = 16'h0100;
    localparam [15:0] ST_SEL_IR = 16'h0200;
    localparam [15:0] ST_CAP_IR = 16'h0400;
    localparam [15:0] ST_SH_IR = 16'h0800;
    localparam [15:0] ST_EX1_IR = 16'h1000;
    localparam [15:0] ST_PA_IR = 16'h2000;
    localparam [15:0] ST_EX2_IR = 16'h4000;
    localparam [15:0] ST_UP_IR = 16'h8000;

    // ****************************************
    // reset release and link sampling
    // ****************************************
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;
    // reset asserted asynchronously, released through two flops
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    wire tck_s;
    wire tms_s;
    wire tdi_s;
    sstap_sync u_sync_tck (.clk_in(clk_in), .rst_n_in(rst_n), .d_in(tck_in), .q_out(tck_s));
    sstap_sync u_sync_tms (.clk_in(clk_in), .rst_n_in(rst_n), .d_in(tms_in), .q_out(tms_s));
    sstap_sync u_sync_tdi (.clk_in(clk_in), .rst_n_in(rst_n), .d_in(tdi_in), .q_out(tdi_s));

    reg tck_prev_reg;
    wire tck_rise;
    wire tck_fall;
    // edge detection on the synchronised test clock
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tck_prev_reg <= 1'b0;
        end else begin
            tck_prev_reg <= tck_s;
        end
    end
    assign tck_rise = tck_s & ~tck_prev_reg;
    assign tck_fall = ~tck_s & tck_prev_reg;

    // ****************************************
    // controller state machine
    // ****************************************
    reg [15:0] state_reg;
    reg [15:0] state_next;
    // next state from mode-select; five highs reach reset from anywhere
    always @* begin
        state_next = ST_RESET;
        case (state_reg)
            ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms_s ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: state_next = tms_s ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_next = tms_s ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms_s ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: state_next = tms_s ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_next = tms_s ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            default: state_next = ST_RESET;
        endcase
    end

    // state advances on each rising test-clock edge
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // identification value
    // ****************************************
    // assemble the fixed identification word
    function [31:0] sstap_id_word;
        input dummy;
        begin
            sstap_id_word = {`SSTAP_ID_REV, 2'h0, `SSTAP_DESC_DENSITY, 1'h0, `SSTAP_DESC_WIDTH, 1'h0,
                `SSTAP_DESC_DLL, 1'h0, `SSTAP_DESC_QDR, 1'h0, `SSTAP_DESC_BURST, 1'h0, `SSTAP_DESC_SEPIO, 1'h0,
                `SSTAP_ID_MAKER, `SSTAP_ID_PRESENT};
        end
    endfunction
    wire [31:0] id_value = sstap_id_word(1'b0);

    // ****************************************
    // instruction and data registers
    // ****************************************
    reg [2:0] ir_shift_reg;
    reg [2:0] ir_reg;
    reg [31:0] id_reg;
    reg skip_reg;
    reg [106:0] chain_reg;
    wire sel_id = (ir_reg == `SSTAP_INS_IDENT);
    wire sel_skip = (ir_reg == `SSTAP_INS_SKIP);
    // capture-type codes; reserved codes also land on the chain
    wire sel_chain = ~sel_id & ~sel_skip;

    // capture and shift on rising test-clock edges
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_reg <= 3'h0;
            ir_reg <= `SSTAP_INS_IDENT;
            id_reg <= 32'h0;
            skip_reg <= 1'b0;
            chain_reg <= 107'h0;
        end else if (tck_rise) begin
            case (state_reg)
                ST_RESET: begin
                    ir_reg <= `SSTAP_INS_IDENT;
                end
                ST_CAP_IR: begin
                    ir_shift_reg <= {1'b0, `SSTAP_IR_CAPTURE};
                end
                ST_SH_IR: begin
                    ir_shift_reg <= {tdi_s, ir_shift_reg[2:1]};
                end
                ST_UP_IR: begin
                    ir_reg <= ir_shift_reg;
                end
                ST_CAP_DR: begin
                    if (sel_id) begin
                        id_reg <= id_value;
                    end else if (sel_skip) begin
                        skip_reg <= 1'b0;
                    end else begin
                        chain_reg <= ring_in;
                    end
                end
                ST_SH_DR: begin
                    if (sel_id) begin
                        id_reg <= {tdi_s, id_reg[31:1]};
                    end else if (sel_skip) begin
                        skip_reg <= tdi_s;
                    end else begin
                        chain_reg <= {tdi_s, chain_reg[106:1]};
                    end
                end
                default: begin
                    // update-dr transfers nothing to the pins
                    ir_reg <= ir_reg;
                end
            endcase
            // entering test-logic-reset selects identification at once
            if (state_next == ST_RESET) begin
                ir_reg <= `SSTAP_INS_IDENT;
            end
        end
    end

    // ****************************************
    // serial output and memory output control
    // ****************************************
    reg shifting_reg;
    // tdo and its enable change only on falling test-clock edges; mem_hiz_out follows ir_reg every clock
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
            shifting_reg <= 1'b0;
            mem_hiz_out <= 1'b0;
        end else begin
            // only sample-z floats memory outputs; identification and bypass leave it alone
            mem_hiz_out <= (ir_reg == `SSTAP_INS_SAMPLE_HIZ);
            if (tck_fall) begin
                shifting_reg <= (state_reg == ST_SH_DR) | (state_reg == ST_SH_IR);
                tdo_oe_out <= (state_reg == ST_SH_DR) | (state_reg == ST_SH_IR);
                // tdo only moves in shift states, holding its last bit otherwise
                if (state_reg == ST_SH_IR) begin
                    tdo_out <= ir_shift_reg[0];
                end else if (state_reg != ST_SH_DR) begin
                    tdo_out <= tdo_out;
                end else if (sel_id) begin
                    tdo_out <= id_reg[0];
                end else if (sel_skip) begin
                    tdo_out <= skip_reg;
                end else if (sel_chain) begin
                    tdo_out <= chain_reg[0];
                end
            end
        end
    end
endmodule // sstap_top
`default_nettype wire

/* File: pkg/sstap_consts.vh */
// constants for the sram scan test access port
`ifndef SSTAP_CONSTS_VH
`define SSTAP_CONSTS_VH
// instruction codes
`define SSTAP_INS_SAMPLE_EXT 3'h0
`define SSTAP_INS_IDENT 3'h1
`define SSTAP_INS_SAMPLE_HIZ 3'h2
`define SSTAP_INS_SAMPLE_PRE 3'h4
`define SSTAP_INS_SKIP 3'h7
// widths
`define SSTAP_IR_W 3
`define SSTAP_CHAIN_W 107
`define SSTAP_ID_W 32
// capture-ir pattern in the two low bits
`define SSTAP_IR_CAPTURE 2'h1
// identification fields: bit 0 presence, 11:1 maker, 28:12 descriptor, 31:29 revision
`define SSTAP_ID_PRESENT 1'h1
`define SSTAP_ID_MAKER_LSB 1
`define SSTAP_ID_DESC_LSB 12
`define SSTAP_ID_REV_LSB 29
// arbitrary neutral identity values
`define SSTAP_ID_MAKER 11'h2A5
`define SSTAP_ID_REV 3'h2
// descriptor subfields: density, data_width_subfield, dll, qdr, burst, separate io
`define SSTAP_DESC_DENSITY 3'h1
`define SSTAP_DESC_WIDTH 2'h2
`define SSTAP_DESC_DLL 1'h1
`define SSTAP_DESC_QDR 1'h0
`define SSTAP_DESC_BURST 1'h0
`define SSTAP_DESC_SEPIO 1'h0
`endif

/* File: core/sstap_sync.v */
// two flip-flop synchroniser for link inputs
`timescale 1ns/10ps
`default_nettype none
module sstap_sync (
    input wire clk_in,
    input wire rst_n_in,
    input wire d_in,
    output reg q_out
);
    reg meta_reg;
    // first stage feeds only the second
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // sstap_sync
`default_nettype wire

/* File: bench/sstap_monitor.sv */
// checker for the scan test access port outputs
`timescale 1ns/10ps
`default_nettype none
module sstap_monitor (
    input wire clk_in,
    input wire rst_n_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire [106:0] ring_in,
    input wire tdo_out,
    input wire tdo_oe_out,
    input wire mem_hiz_out
);
    reg tck_d_reg;
    reg [2:0] hi_cnt_reg;
    // counts tck rises seen with mode-select high, saturating
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tck_d_reg <= 1'b0;
            hi_cnt_reg <= 3'h0;
        end else begin
            tck_d_reg <= tck_in;
            if (tck_in && !tck_d_reg)
                hi_cnt_reg <= !tms_in ? 3'h0 : (hi_cnt_reg == 3'h7 ? 3'h7 : hi_cnt_reg + 3'h1);
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // a tck fall or rise seen two to five cycles ago
    sequence s_after_fall;
        !$past(tck_in, 2) && $past(tck_in, 6);
    endsequence
    sequence s_after_rise;
        $past(tck_in, 2) && !$past(tck_in, 6);
    endsequence
    AST_TDO_ON_FALL: assert property ($changed(tdo_out) |-> s_after_fall)
        else $error("tdo moved away from a tck fall");
    AST_OE_ON_FALL: assert property ($changed(tdo_oe_out) |-> s_after_fall)
        else $error("tdo enable moved away from a tck fall");
    AST_HIZ_ON_RISE: assert property ($changed(mem_hiz_out) |-> s_after_rise)
        else $error("high impedance moved away from a tck rise");
    AST_TLR_CLEARS: assert property (hi_cnt_reg == 3'h5 |-> ##[0:8] (!mem_hiz_out && !tdo_oe_out))
        else $error("five mode-select highs did not reset");
    AST_TDO_HOLDS: assert property (!tdo_oe_out && !$past(tdo_oe_out) |-> $stable(tdo_out))
        else $error("tdo changed while disabled");
    AST_HIZ_NOT_SHIFT: assert property ($rose(mem_hiz_out) |-> !tdo_oe_out)
        else $error("high impedance rose while shifting");
    AST_OE_SPAN: assert property ($rose(tdo_oe_out) |-> tdo_oe_out[*7])
        else $error("shift enable shorter than a tck period");
    AST_OE_GAP: assert property ($fell(tdo_oe_out) |-> !tdo_oe_out[*8])
        else $error("shift enable came back too soon");
endmodule // sstap_monitor
bind sstap_top sstap_monitor sstap_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck_in),
    .tms_in(tms_in), .tdi_in(tdi_in), .ring_in(ring_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .mem_hiz_out(mem_hiz_out));
`default_nettype wire

/* File: bench/sstap_ctrl_model.sv */
// boundary-scan controller model driving the test link
`timescale 1ns/10ps
`default_nettype none
module sstap_ctrl_model (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    // tck rests low between calls
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one 200 ns period; tdo read late since its sync delay nears the rise
    task automatic tick(input logic t, input logic d, output logic q);
        tms_out = t;
        tdi_out = d;
        #100 tck_out = 1'b1;
        #95 q = tdo_in;
        #5 tck_out = 1'b0;
    endtask
    // walk the state machine, tdi toggling as it is unused
    task automatic moves(input logic [7:0] pat, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            tick(pat[i], ~tdi_out, q);
    endtask
endmodule // sstap_ctrl_model
`default_nettype wire

/* File: bench/sram_scan_test_access_test.sv */
// self-checking bench for the scan test access port
`timescale 1ns/10ps
`default_nettype none
`include "sstap_consts.vh"
module sram_scan_test_access_test;
    logic clk_in;
    logic rst_n_in;
    logic [106:0] ring_in;
    wire tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, mem_hiz_out;
    int n_fail = 0;
    int cmp_count = 0;
    logic [127:0] got;
    logic [2:0] cap;
    localparam logic [31:0] ID_EXP = {`SSTAP_ID_REV, 2'h0, `SSTAP_DESC_DENSITY, 1'h0, `SSTAP_DESC_WIDTH, 1'h0,
        `SSTAP_DESC_DLL, 1'h0, `SSTAP_DESC_QDR, 1'h0, `SSTAP_DESC_BURST, 1'h0, `SSTAP_DESC_SEPIO, 1'h0,
        `SSTAP_ID_MAKER, 1'h1};
    sstap_top sstap_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck_in), .tms_in(tms_in),
        .tdi_in(tdi_in), .ring_in(ring_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .mem_hiz_out(mem_hiz_out));
    sstap_ctrl_model sstap_ctrl_model_inst (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in), .tdo_in(tdo_out));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // shift n bits through the selected data register from idle
    task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        sstap_ctrl_model_inst.moves(8'h1, 3);
        for (int i = 0; i < n; i++) begin
            sstap_ctrl_model_inst.tick(i == n - 1, din[i], q);
            dout[i] = q;
            if (i == 0) chk("oe_shift", 1'h1, tdo_oe_out);
        end
        sstap_ctrl_model_inst.moves(8'h1, 2);
    endtask
    // load an instruction from idle, returning the captured bits
    task automatic go_ir(input logic [2:0] code, output logic [2:0] c);
        logic q;
        sstap_ctrl_model_inst.moves(8'h3, 4);
        for (int i = 0; i < 3; i++) begin
            sstap_ctrl_model_inst.tick(i == 2, code[i], q);
            c[i] = q;
        end
        sstap_ctrl_model_inst.moves(8'h1, 2);
    endtask
    task automatic t_ident();
        scan_dr(32, 128'h0, got);
        chk("ident", ID_EXP, got);
        chk("hiz", 1'h0, mem_hiz_out);
        chk("oe_idle", 1'h0, tdo_oe_out);
        $display("test ident done");
    endtask
    task automatic t_chain();
        for (int k = 0; k < 3; k++) begin
            go_ir(3'(k * 2), cap);
            chk("capture_ir", 2'h1, cap[1:0]);
            chk("hiz", k == 1, mem_hiz_out);
            @(posedge clk_in) #2 ring_in = {8'h5A, {12{8'hC6}}, 3'(k * 2)};
            scan_dr(110, 128'h3, got);
            chk("chain", {18'h0, 3'h3, ring_in}, got);
            @(posedge clk_in) #2 ring_in = ~ring_in;
            scan_dr(107, 128'h0, got);
            chk("recapture", {21'h0, ring_in}, got);
        end
        $display("test chain done");
    endtask
    task automatic t_skip();
        go_ir(3'h7, cap);
        scan_dr(5, 128'h1B, got);
        chk("skip", 128'h16, got);
        chk("hiz", 1'h0, mem_hiz_out);
        $display("test skip done");
    endtask
    task automatic t_reset();
        go_ir(3'h2, cap);
        chk("hiz_set", 1'h1, mem_hiz_out);
        sstap_ctrl_model_inst.moves(8'h1F, 6);
        chk("hiz_clear", 1'h0, mem_hiz_out);
        scan_dr(32, 128'h0, got);
        chk("ident_again", ID_EXP, got);
        $display("test reset done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard
    initial begin
        #1000000;
        n_fail++;
        $display("mismatch watchdog expected finish seen hang");
        stop_test();
    end
    initial begin
        rst_n_in = 1'b0;
        ring_in = '0;
        repeat (8) @(posedge clk_in);
        #2 rst_n_in = 1'b1;
        repeat (10) @(posedge clk_in);
        #2;
        sstap_ctrl_model_inst.moves(8'h0, 1);
        t_ident();
        t_chain();
        t_skip();
        t_reset();
        stop_test();
    end
endmodule // sram_scan_test_access_test
`default_nettype wire
